//--- design/sfp_pkg.sv
// Constants and types for the serial flash command and status front end.
// Assumes a serial host in clock mode 0 or 3 and an array outside this block.
package sfp_pkg;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_BYTE_PROG = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE_ARM = 8'h06;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_STATUS_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_AUTO_INC = 8'had;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  // Status bit positions and power-up value
  localparam int ST_BUSY = 0;
  localparam int ST_WLATCH = 1;
  localparam int ST_LVL_LO = 2;
  localparam int ST_LVL_HI = 4;
  localparam int ST_RSVD = 5;
  localparam int ST_AUTO_INC = 6;
  localparam int ST_LOCK = 7;
  localparam logic [7:0] ST_RESET = 8'h1c;
  // Whole bytes in a frame, opcode included; BIT_LAST is the last bit index in a byte
  localparam logic [2:0] NB_OP = 3'h1;
  localparam logic [2:0] NB_ADDR = 3'h4;
  localparam logic [2:0] NB_FAST = 3'h5;
  localparam logic [2:0] NB_PROG = 3'h5;
  localparam logic [2:0] NB_AUTO_FIRST = 3'h6;
  localparam logic [2:0] NB_AUTO_NEXT = 3'h3;
  localparam logic [2:0] NB_STATUS_WRITE = 3'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // System clock period
  localparam int CLK_NS = 25;

  typedef enum logic [3:0] {
    K_NONE = 4'h0,
    K_ARM = 4'h1,
    K_DISARM = 4'h2,
    K_SW_ENABLE = 4'h3,
    K_STATUS_WRITE = 4'h4,
    K_BYTE_PROG = 4'h5,
    K_AUTO_START = 4'h6,
    K_AUTO_NEXT = 4'h7,
    K_SECTOR = 4'h8,
    K_BLOCK = 4'h9,
    K_CHIP = 4'ha,
    K_IGNORED = 4'hb
  } sfp_kind_t;

  // Frame record built on the serial clock
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] addr;
    logic [15:0] dat;
    logic [2:0] nbytes;
    logic partial;
  } sfp_frame_t;

  // Order to the array: one-cycle valid
  typedef struct packed {
    logic valid;
    sfp_kind_t kind;
    logic [23:0] addr;
    logic [15:0] dat;
  } sfp_arr_cmd_t;
endpackage

//--- design/sfp_flash_front.sv
// Serial flash command interpreter with the volatile status register.
// Assumes the array answers rd_data_in combinationally on the serial clock
// and carries out the orders on arr_cmd_out while busy stands.
`timescale 1ns/1ps
module sfp_flash_front #(
  parameter int AW = 19,
  parameter int PROG_NS = 10000,
  parameter int SECTOR_NS = 200000,
  parameter int BLOCK_NS = 400000,
  parameter int CHIP_NS = 800000
) (
  // System side
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Serial link
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  output logic so_out,
  output logic so_oe_out,
  // Array side
  output logic [23:0] rd_addr_out,
  input wire logic [7:0] rd_data_in,
  output sfp_pkg::sfp_arr_cmd_t arr_cmd_out,
  output logic [7:0] status_out
);
  import sfp_pkg::*;

  function automatic logic [31:0] cycles(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return 32'(c);
  endfunction

  function automatic logic [23:0] wrap_inc(input logic [23:0] a, input int step);
    logic [23:0] m;
    m = 24'((64'h1 << AW) - 64'h1);
    return (a + 24'(step)) & m;
  endfunction

  // Level 1..3 guard the top eighth, quarter, half; 4..7 all
  function automatic logic prot(input logic [23:0] a, input logic [2:0] lvl);
    logic [2:0] t;
    t = a[AW-1 -: 3];
    case (lvl)
      3'h0: prot = 1'b0;
      3'h1: prot = (t == 3'h7);
      3'h2: prot = (t[2:1] == 2'h3);
      3'h3: prot = t[2];
      default: prot = 1'b1;
    endcase
  endfunction

  localparam logic [31:0] PROG_CYC = cycles(PROG_NS);
  localparam logic [31:0] SECTOR_CYC = cycles(SECTOR_NS);
  localparam logic [31:0] BLOCK_CYC = cycles(BLOCK_NS);
  localparam logic [31:0] CHIP_CYC = cycles(CHIP_NS);
  localparam logic [23:0] TOP = 24'((64'h1 << AW) - 64'h1);

  // Serial clock domain
  logic in_frame;
  logic [2:0] bit_cnt;
  logic [7:0] sh;
  logic [7:0] next_byte;
  logic frm_tgl;
  sfp_frame_t rec;
  logic stream_rd;
  logic stream_st;
  logic [23:0] rd_addr;
  logic [7:0] st_s1;
  logic [7:0] st_s2;
  logic [7:0] so_sh;
  logic so_oe;
  logic byte_done;

  assign next_byte = {sh[6:0], si_in};
  assign byte_done = in_frame && (bit_cnt == BIT_LAST);

  // Select high ends the frame at once
  always_ff @(posedge sck_in or posedge cs_n_in)
  begin
    if (cs_n_in)
      in_frame <= 1'b0;
    else
      in_frame <= 1'b1;
  end

  // One toggle per frame that saw clock edges
  always_ff @(posedge sck_in or posedge rst_in)
  begin
    if (rst_in)
      frm_tgl <= 1'b0;
    else if (!in_frame)
      frm_tgl <= ~frm_tgl;
  end

  always_ff @(posedge sck_in)
  begin
    if (!in_frame)
    begin
      bit_cnt <= 3'h1;
      sh <= {7'h0, si_in};
      rec.nbytes <= 3'h0;
      rec.partial <= 1'b1;
    end
    else
    begin
      bit_cnt <= bit_cnt + 3'h1;
      sh <= next_byte;
      rec.partial <= (bit_cnt != BIT_LAST);
      if (byte_done && rec.nbytes != 3'h7)
        rec.nbytes <= rec.nbytes + 3'h1;
      // Bytes of the frame by position
      if (byte_done)
      begin
        case (rec.nbytes)
          3'h0: rec.op <= next_byte;
          3'h1: rec.addr[23:16] <= next_byte;
          3'h2: rec.addr[15:8] <= next_byte;
          3'h3: rec.addr[7:0] <= next_byte;
          3'h4: rec.dat[15:8] <= next_byte;
          3'h5: rec.dat[7:0] <= next_byte;
          default: rec.dat <= rec.dat;
        endcase
      end
    end
  end

  // Read streams and their address
  always_ff @(posedge sck_in)
  begin
    if (!in_frame)
    begin
      stream_rd <= 1'b0;
      stream_st <= 1'b0;
    end
    else if (byte_done)
    begin
      if (stream_rd)
        rd_addr <= wrap_inc(rd_addr, 1);
      else if (rec.nbytes == NB_ADDR - 3'h1 && rec.op == OP_READ)
      begin
        stream_rd <= 1'b1;
        rd_addr <= {rec.addr[23:8], next_byte} & TOP;
      end
      else if (rec.nbytes == NB_FAST - 3'h1 && rec.op == OP_FAST_READ)
      begin
        // Address already complete; the byte just in is the dummy
        stream_rd <= 1'b1;
        rd_addr <= rec.addr & TOP;
      end
      if (rec.nbytes == 3'h0 && next_byte == OP_STATUS_READ)
        stream_st <= 1'b1;
    end
  end

  // Status bits change only while select is high, except busy and the write latch that clears as busy ends
  always_ff @(posedge sck_in)
  begin
    st_s1 <= status_out;
    st_s2 <= st_s1;
  end

  always_ff @(negedge sck_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      so_sh <= 8'h00;
      so_oe <= 1'b0;
    end
    else if (in_frame && (stream_rd || stream_st))
    begin
      so_oe <= 1'b1;
      if (bit_cnt == 3'h0)
        so_sh <= stream_st ? st_s2 : rd_data_in;
      else
        so_sh <= {so_sh[6:0], 1'b0};
    end
  end

  assign so_out = so_sh[7];
  assign so_oe_out = so_oe;
  assign rd_addr_out = rd_addr;

  // System clock domain
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic wp_s1;
  logic wp_s2;
  logic tg_s1;
  logic tg_s2;
  logic last_tg;
  logic done;
  logic write_latch_bit;
  logic [2:0] lvl;
  logic lock;
  logic auto_inc;
  logic [23:0] auto_addr;
  logic arm_prev;
  logic wel_drop;
  logic [31:0] busy_cnt;
  logic busy;
  logic auto_top;
  sfp_kind_t kind;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      last_tg <= 1'b0;
    end
    else
    begin
      cs_s1 <= cs_n_in;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      wp_s1 <= wp_n_in;
      wp_s2 <= wp_s1;
      tg_s1 <= frm_tgl;
      tg_s2 <= tg_s1;
      if (cs_s2 && !cs_s3)
        last_tg <= tg_s2;
    end
  end

  // The record is still while the serial clock stands after the frame
  assign done = cs_s2 && !cs_s3 && (tg_s2 != last_tg);
  assign busy = (busy_cnt != 32'h0);
  assign auto_top = (auto_addr >= TOP - 24'h1);

  always_comb
  begin
    kind = K_NONE;
    if (done && !rec.partial && !busy)
    begin
      kind = K_IGNORED;
      if (auto_inc)
      begin
        if (rec.op == OP_WRITE_DISARM)
          kind = K_DISARM;
        else if (rec.op == OP_AUTO_INC && rec.nbytes >= NB_AUTO_NEXT && !prot(auto_addr, lvl))
          kind = K_AUTO_NEXT;
      end
      else
      begin
        case (rec.op)
          OP_WRITE_ARM: kind = K_ARM;
          OP_WRITE_DISARM: kind = K_DISARM;
          OP_STATUS_WRITE_ENABLE: kind = K_SW_ENABLE;
          OP_STATUS_WRITE:
            if (rec.nbytes >= NB_STATUS_WRITE && arm_prev && !(!wp_s2 && lock))
              kind = K_STATUS_WRITE;
          OP_BYTE_PROG:
            if (write_latch_bit && rec.nbytes >= NB_PROG && !prot(rec.addr, lvl))
              kind = K_BYTE_PROG;
          OP_AUTO_INC:
            if (write_latch_bit && rec.nbytes >= NB_AUTO_FIRST && !prot(rec.addr, lvl))
              kind = K_AUTO_START;
          OP_SECTOR_ERASE:
            if (write_latch_bit && rec.nbytes >= NB_ADDR && !prot(rec.addr, lvl))
              kind = K_SECTOR;
          OP_BLOCK_ERASE:
            if (write_latch_bit && rec.nbytes >= NB_ADDR && !prot(rec.addr, lvl))
              kind = K_BLOCK;
          OP_CHIP_ERASE_A, OP_CHIP_ERASE_B:
            if (write_latch_bit && rec.nbytes >= NB_OP && lvl == 3'h0)
              kind = K_CHIP;
          default: kind = K_IGNORED;
        endcase
      end
    end
  end

  // Status write enable lasts one following frame
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      arm_prev <= 1'b0;
    else if (done)
      arm_prev <= (kind == K_ARM || kind == K_SW_ENABLE);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      write_latch_bit <= ST_RESET[ST_WLATCH];
      wel_drop <= 1'b0;
    end
    else if (kind == K_ARM)
      write_latch_bit <= 1'b1;
    else if (kind == K_DISARM || kind == K_STATUS_WRITE)
      write_latch_bit <= 1'b0;
    else if (kind == K_AUTO_NEXT && auto_top)
      write_latch_bit <= 1'b0;
    else if (kind == K_AUTO_START && (rec.addr & TOP) >= TOP - 24'h1)
      write_latch_bit <= 1'b0;
    else if (kind == K_BYTE_PROG || kind == K_SECTOR || kind == K_BLOCK || kind == K_CHIP)
      wel_drop <= 1'b1;
    else if (wel_drop && busy_cnt == 32'h1)
    begin
      write_latch_bit <= 1'b0;
      wel_drop <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      lvl <= ST_RESET[ST_LVL_HI:ST_LVL_LO];
      lock <= ST_RESET[ST_LOCK];
    end
    else if (kind == K_STATUS_WRITE)
    begin
      lock <= rec.addr[16 + ST_LOCK];
      if (!lock)
        lvl <= rec.addr[16 + ST_LVL_HI:16 + ST_LVL_LO];
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      auto_inc <= ST_RESET[ST_AUTO_INC];
      auto_addr <= 24'h0;
    end
    else if (kind == K_AUTO_START)
    begin
      auto_inc <= (rec.addr & TOP) < TOP - 24'h1;
      auto_addr <= wrap_inc(rec.addr, 2);
    end
    else if (kind == K_AUTO_NEXT)
    begin
      auto_inc <= !auto_top;
      auto_addr <= wrap_inc(auto_addr, 2);
    end
    else if (kind == K_DISARM)
      auto_inc <= 1'b0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      busy_cnt <= 32'h0;
    else
    begin
      case (kind)
        K_BYTE_PROG, K_AUTO_START, K_AUTO_NEXT: busy_cnt <= PROG_CYC;
        K_SECTOR: busy_cnt <= SECTOR_CYC;
        K_BLOCK: busy_cnt <= BLOCK_CYC;
        K_CHIP: busy_cnt <= CHIP_CYC;
        default: if (busy) busy_cnt <= busy_cnt - 32'h1;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      arr_cmd_out <= '0;
    else
    begin
      arr_cmd_out.valid <= (kind >= K_BYTE_PROG && kind <= K_CHIP);
      arr_cmd_out.kind <= kind;
      arr_cmd_out.addr <= (kind == K_AUTO_NEXT) ? auto_addr : rec.addr & TOP;
      arr_cmd_out.dat <= (kind == K_AUTO_NEXT) ? rec.addr[23:8] : rec.dat;
    end
  end

  assign status_out = {lock, auto_inc, 1'b0, lvl, write_latch_bit, busy};
endmodule

//--- tb/sfp_flash_front_monitor.sv
// Port assertions for the serial flash front end.
// Assumes it is bound onto sfp_flash_front.
`timescale 1ns/1ps
module sfp_flash_front_monitor
  import sfp_pkg::*;
(
  // Watched ports
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic so_oe_out,
  input wire sfp_pkg::sfp_arr_cmd_t arr_cmd_out,
  input wire logic [7:0] status_out
);
  default clocking mon_cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  rsvd_bit_zero_a: assert property (status_out[ST_RSVD] == 1'b0)
    else $error("reserved status bit set");
  reset_status_a: assert property ($fell(rst_in) |-> status_out == ST_RESET)
    else $error("status not at power-up value");
  so_quiet_a: assert property (cs_n_in |-> !so_oe_out)
    else $error("serial output driven while deselected");
  cmd_needs_latch_a: assert property (arr_cmd_out.valid |-> $past(status_out[1:0], 2) == 2'b10)
    else $error("array order without latch or while busy");
  chip_unprot_a: assert property (arr_cmd_out.valid && arr_cmd_out.kind == K_CHIP |->
    $past(status_out[ST_LVL_HI:ST_LVL_LO], 2) == 3'h0)
    else $error("chip erase with protection set");
  busy_follows_a: assert property (arr_cmd_out.valid |-> ##[0:2] status_out[ST_BUSY])
    else $error("busy missing after array order");
  lock_freeze_a: assert property ($changed(status_out[4:2]) |-> !$past(status_out[ST_LOCK]))
    else $error("level bits changed while locked");
  latch_set_idle_a: assert property ($rose(status_out[ST_WLATCH]) |-> cs_n_in && $past(cs_n_in))
    else $error("latch set inside a frame");
  auto_armed_a: assert property ($rose(status_out[ST_AUTO_INC]) |-> $past(status_out[ST_WLATCH]))
    else $error("auto mode entered without latch");
endmodule

bind sfp_flash_front sfp_flash_front_monitor mon_u (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .cs_n_in(cs_n_in),
  .so_oe_out(so_oe_out),
  .arr_cmd_out(arr_cmd_out),
  .status_out(status_out)
);

//--- tb/sfp_spi_host.sv
// Serial host model, clock mode 0, 32 ns serial clock.
// Assumes the bench calls frame and waits for it to return.
`timescale 1ns/1ps
module sfp_spi_host (
  // Serial link
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b0;
    si_out = 1'b0;
    // Rise after time zero so the link logic sees a deselect edge
    cs_n_out <= 1'b1;
  end

  // Sends nb bits MSB first, then clocks nr bits back; clock stands between frames
  task automatic frame(input logic [47:0] d, input int nb, input int nr, output logic [15:0] q);
    q = 16'h0;
    #3.3 cs_n_out = 1'b0;
    for (int i = 0; i < nb + nr; i++)
    begin
      #8 si_out = (i < nb) ? d[47 - i] : ~si_out;
      #8 sck_out = 1'b1;
      if (i >= nb)
        q = {q[14:0], so_oe_in ? so_in : ~q[0]};
      #16 sck_out = 1'b0;
    end
    #16 cs_n_out = 1'b1;
    // Idle gap lets the frame execute before anything else
    #300;
  endtask
endmodule

//--- tb/sfp_flash_front_tb.sv
// Self-checking bench for the serial flash front end.
// Assumes the host model sfp_spi_host and the bound port checker.
`timescale 1ns/1ps
module sfp_flash_front_tb;
  import sfp_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b0;
  logic wp_n_in = 1'b1;
  logic sck, cs_n, si, so, so_oe;
  logic [23:0] rd_addr;
  logic [7:0] st_out, st;
  logic [15:0] q;
  sfp_arr_cmd_t cmd, last;
  int errors = 0;
  int n_checks = 0;
  int ncmd = 0;
  logic [7:0] ops [6] = '{OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_BYTE_PROG,
    OP_AUTO_INC};
  sfp_kind_t kinds [6] = '{K_SECTOR, K_BLOCK, K_CHIP, K_CHIP, K_BYTE_PROG, K_AUTO_START};
  int nbs [6] = '{32, 32, 8, 8, 40, 48};
  logic [7:0] pres [3] = '{8'h00, OP_WRITE_ARM, OP_STATUS_WRITE_ENABLE};

  always #12.5 clk_sys_in = ~clk_sys_in;

  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] + {5'h0, x[18:16]};
  endfunction

  sfp_flash_front #(.PROG_NS(500), .SECTOR_NS(550), .BLOCK_NS(600), .CHIP_NS(650)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .wp_n_in(wp_n_in), .so_out(so), .so_oe_out(so_oe), .rd_addr_out(rd_addr),
    .rd_data_in(mem(rd_addr)), .arr_cmd_out(cmd), .status_out(st_out));
  sfp_spi_host host_u (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_in(so_oe));

  always @(posedge clk_sys_in)
    if (cmd.valid)
    begin
      last <= cmd;
      ncmd <= ncmd + 1;
    end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic send(input logic [47:0] d, input int nb);
    host_u.frame(d, nb, 0, q);
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 200 && st_out[ST_BUSY] !== 1'b0; k++)
      @(posedge clk_sys_in);
    if (k == 200)
    begin
      errors++;
      $display("ERROR %0t busy stuck", $time);
      results();
    end
  endtask

  // Optional prefix frame, then a status write; st tracks the expected register
  task automatic swr(input logic wp, input logic [7:0] pre, input logic [7:0] d);
    @(posedge clk_sys_in);
    wp_n_in <= wp;
    if (pre != 8'h00)
      send({pre, 40'h0}, 8);
    if (pre == OP_WRITE_ARM)
      st[ST_WLATCH] = 1'b1;
    send({OP_STATUS_WRITE, d, 32'h0}, 16);
    if (pre != 8'h00 && (wp || !st[ST_LOCK]))
      st = {d[7], 2'b00, (st[ST_LOCK] ? st[4:2] : d[4:2]), 2'b00};
    chk(24'(st_out), 24'(st));
  endtask

  initial
  begin
    logic [23:0] a, b;
    logic [7:0] d;
    int n;
    void'($urandom(32'he31f));
    // Raised after time zero so the serial-side reset sees an edge
    rst_in <= 1'b1;
    st = ST_RESET;
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk(24'(st_out), 24'(st));
    host_u.frame({OP_STATUS_READ, 40'h0}, 8, 16, q);
    chk(24'(q), {8'h0, ST_RESET, ST_RESET});
    $display("test reset done");
    for (int i = 0; i < 6; i++)
      swr(1'($urandom), pres[$urandom % 3], 8'($urandom));
    swr(1'b1, OP_WRITE_ARM, 8'h00);
    swr(1'b0, OP_STATUS_WRITE_ENABLE, 8'h00);
    swr(1'b1, OP_WRITE_ARM, 8'h80);
    swr(1'b0, OP_WRITE_ARM, 8'h00);
    swr(1'b1, OP_WRITE_ARM, 8'h1c);
    $display("test status write done");
    for (int i = 0; i < 6; i++)
    begin
      a = 24'($urandom) & 24'h03fff0;
      d = 8'($urandom);
      n = ncmd;
      send({ops[i], a, d, ~d}, nbs[i]);
      chk(24'(ncmd), 24'(n));
      send({OP_WRITE_ARM, 40'h0}, 8);
      send({ops[i], a, d, ~d}, nbs[i]);
      chk(24'(st_out[1:0]), 24'h3);
      chk(24'(ncmd), 24'(n + 1));
      chk(24'(last.kind), 24'(kinds[i]));
      if (nbs[i] > 8)
        chk(last.addr, a);
      if (nbs[i] > 32)
        chk(24'(last.dat[15:8]), 24'(d));
      wait_idle();
      chk(24'(st_out[6:1]), ops[i] == OP_AUTO_INC ? 24'h21 : 24'h0);
    end
    n = ncmd;
    send({OP_AUTO_INC, ~d, d, 24'h0}, 24);
    chk(24'(ncmd), 24'(n + 1));
    chk(24'(last.kind), 24'(K_AUTO_NEXT));
    chk(last.addr, a + 24'h2);
    chk(24'(last.dat), {8'h0, ~d, d});
    wait_idle();
    send({OP_WRITE_DISARM, 40'h0}, 8);
    chk(24'(st_out[6:1]), 24'h0);
    $display("test program erase done");
    swr(1'b1, OP_WRITE_ARM, 8'h04);
    n = ncmd;
    send({OP_WRITE_ARM, 40'h0}, 8);
    send({OP_CHIP_ERASE_B, 40'h0}, 8);
    chk(24'(ncmd), 24'(n));
    send({OP_WRITE_DISARM, 40'h0}, 8);
    send({OP_WRITE_ARM, 40'h0}, 15);
    chk(24'(st_out[ST_WLATCH]), 24'h0);
    $display("test refusals done");
    for (int i = 0; i < 2; i++)
    begin
      a = (i == 0) ? 24'h07ffff : 24'($urandom) & 24'h07ffff;
      host_u.frame({(i == 0) ? OP_READ : OP_FAST_READ, a, 16'h0}, 32 + 8 * i, 16, q);
      b = (a + 24'h1) & 24'h07ffff;
      chk(24'(q), {8'h0, mem(a), mem(b)});
    end
    $display("test reads done");
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk(24'(st_out), 24'(ST_RESET));
    host_u.frame({OP_STATUS_READ, 40'h0}, 8, 8, q);
    chk(24'(q[7:0]), 24'(ST_RESET));
    $display("test mid-run reset done");
    results();
  end
endmodule
